//--- hdc_defs.svh
/*
   offsets, reset values, field positions and fixed figures of the haptic
   drive calibration register bank.
   assumes it is included by bare name before the package line or module.
*/
`ifndef HDC_DEFS_SVH
`define HDC_DEFS_SVH

// ==========================================================
// register offsets on the serial control bus
`define HDC_OFS_PEAK_DRIVE 8'h15
`define HDC_OFS_NOMINAL 8'h16
`define HDC_OFS_OD_LIMIT 8'h17
`define HDC_OFS_CAL_LOSS 8'h18
`define HDC_OFS_CAL_BEMF 8'h19

// ==========================================================
// reset values
`define HDC_RST_PEAK_DRIVE 8'hFF
`define HDC_RST_NOMINAL 8'h3E
`define HDC_RST_OD_LIMIT 8'h8C
`define HDC_RST_CAL_LOSS 8'h0C
`define HDC_RST_CAL_BEMF 8'h6F
`define HDC_RD_UNMAPPED 8'h00

// ==========================================================
// field positions and fixed figures
`define HDC_RW_BIT 0
`define HDC_ADDR_MSB 7
`define HDC_ADDR_LSB 1
`define HDC_BITS_PER_BYTE 4'h8
`define HDC_FULL_SCALE 8'hFF
`define HDC_BEMF_REF_MV 19'h004C4

`endif

//--- hdc_pkg.sv
/*
   types shared by the haptic drive calibration register bank modules.
   assumes hdc_defs.svh is on the include path.
*/
package hdc_pkg;

   // ==========================================================
   // serial slave states, one-hot
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_ADDR_ACK = 9'h004,
      ST_PTR = 9'h008,
      ST_PTR_ACK = 9'h010,
      ST_WDATA = 9'h020,
      ST_WDATA_ACK = 9'h040,
      ST_RDATA = 9'h080,
      ST_RDATA_ACK = 9'h100
   } hdc_state_type;

   // ==========================================================
   // state records
   typedef struct packed {
      hdc_state_type state;
      logic [3:0] bits;
      logic [7:0] shift;
      logic [7:0] ptr;
      logic ack;
      logic sda_oe;
      logic sda_lvl;
      logic [7:0] peak;
      logic [7:0] nominal;
      logic [7:0] od;
      logic [7:0] loss;
      logic [7:0] bemf;
   } hdc_bank_type;

   typedef struct packed {
      logic cur;
      logic prev;
   } hdc_pin_type;

   typedef struct packed {
      logic [7:0] fullscale;
      logic [7:0] drive;
      logic [8:0] coef;
      logic [18:0] bemf_num;
      logic [11:0] bemf_den;
   } hdc_calc_type;

endpackage

//--- hdc_pin_track.sv
/*
   samples one control bus line and reports its level and edges.
   assumes the line is synchronous to clk_sys.
*/
`timescale 1ns/1ps
module hdc_pin_track
   import hdc_pkg::*;
#(
   parameter logic IDLE_LEVEL = 1'b1
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // line
   input wire logic pin_in,
   // sampled view
   output logic level,
   output logic rise,
   output logic fall
);

   hdc_pin_type q;
   hdc_pin_type d;

   always_comb
   begin
      d = q;
      d.cur = pin_in;
      d.prev = q.cur;
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q <= '{cur: IDLE_LEVEL, prev: IDLE_LEVEL};
      end
      else
      begin
         q <= d;
      end
   end

   assign level = q.cur;
   assign rise = q.cur & ~q.prev;
   assign fall = ~q.cur & q.prev;

endmodule

//--- hdc_drive_calc.sv
/*
   derives the drive engine references from the register bank.
   assumes the register values and engine inputs are on clk_sys.
*/
`timescale 1ns/1ps
`include "hdc_defs.svh"
module hdc_drive_calc
   import hdc_pkg::*;
#(
   parameter logic [3:0] BEMF_SCALE_0 = 4'h1,
   parameter logic [3:0] BEMF_SCALE_1 = 4'h2,
   parameter logic [3:0] BEMF_SCALE_2 = 4'h3,
   parameter logic [3:0] BEMF_SCALE_3 = 4'h4
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // register values
   input wire logic [7:0] peak,
   input wire logic [7:0] nominal,
   input wire logic [7:0] od,
   input wire logic [7:0] loss,
   input wire logic [7:0] bemf,
   // engine side
   input wire logic open_loop,
   input wire logic [7:0] engine_level,
   input wire logic [1:0] backemf_scale_select,
   // derived values
   output logic [7:0] fullscale_ref,
   output logic [7:0] drive_level,
   output logic [8:0] loss_coef_num,
   output logic [18:0] bemf_fb_num,
   output logic [11:0] bemf_fb_den
);

   generate
      if (BEMF_SCALE_0 == 4'h0 || BEMF_SCALE_1 == 4'h0 ||
          BEMF_SCALE_2 == 4'h0 || BEMF_SCALE_3 == 4'h0)
      begin : g_bad_scale
         $error("back-EMF scale of zero cannot serve as a divisor");
      end
   endgenerate

   hdc_calc_type q;
   hdc_calc_type d;
   logic [3:0] scale;

   always_comb
   begin
      case (backemf_scale_select)
         2'h0: scale = BEMF_SCALE_0;
         2'h1: scale = BEMF_SCALE_1;
         2'h2: scale = BEMF_SCALE_2;
         default: scale = BEMF_SCALE_3;
      endcase
   end

   always_comb
   begin
      d = q;
      // open loop references the overdrive limit, closed loop the nominal
      d.fullscale = open_loop ? od : nominal; // [RULE2] [RULE3] [RULE7]
      // engine level capped at peak, both on a 255 = 100 % scale
      d.drive = (engine_level > peak) ? peak : engine_level; // [RULE1]
      // coefficient = coef / 255
      d.coef = 9'(`HDC_FULL_SCALE) + 9'(loss); // [RULE9]
      // volts = bemf_num / bemf_den / 1000
      d.bemf_num = 19'(bemf) * `HDC_BEMF_REF_MV; // [RULE11]
      d.bemf_den = 12'(`HDC_FULL_SCALE) * 12'(scale); // [RULE11]
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign fullscale_ref = q.fullscale;
   assign drive_level = q.drive;
   assign loss_coef_num = q.coef;
   assign bemf_fb_num = q.bemf_num;
   assign bemf_fb_den = q.bemf_den;

endmodule

//--- hdc_regs.sv
/*
   haptic drive calibration register bank with its serial control slave.
   assumes scl and sda are synchronous to clk_sys and that the pad
   resolves sda from sda_oe as an open-drain line.
*/
// Operation
// [RULE1] An 8-bit peak drive value, reset 0xFF, caps drive at value/255.
// [RULE2] An 8-bit nominal level, reset 0x3E, is the closed-loop full scale.
// [RULE3] In open loop the nominal level is ignored for the full scale.
// [RULE4] The host programs the nominal level before calibration starts.
// [RULE5] The host should recalibrate after changing the nominal level.
// [RULE6] An 8-bit overdrive limit, reset 0x8C, bounds overdrive and brake.
// [RULE7] In open loop the overdrive limit is the full-scale reference.
// [RULE8] Calibration stores an 8-bit loss result, reset 0x0C, read/write.
// [RULE9] Playback gain is scaled by one plus the loss result over 255.
// [RULE10] Calibration stores an 8-bit back-EMF level, reset 0x6F.
// [RULE11] Feedback gain derives from back-EMF level/255*1.22 V/scale.
// [RULE12] Calibration results accept host writes; reads give the latest.
`timescale 1ns/1ps
`include "hdc_defs.svh"
module hdc_regs
   import hdc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2A,
   parameter logic [3:0] BEMF_SCALE_0 = 4'h1,
   parameter logic [3:0] BEMF_SCALE_1 = 4'h2,
   parameter logic [3:0] BEMF_SCALE_2 = 4'h3,
   parameter logic [3:0] BEMF_SCALE_3 = 4'h4
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // serial control bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // calibration engine
   input wire logic cal_done,
   input wire logic [7:0] cal_loss_result,
   input wire logic [7:0] cal_backemf_result,
   // playback engine
   input wire logic open_loop,
   input wire logic [7:0] engine_level,
   input wire logic [1:0] backemf_scale_select,
   // register values
   output logic [7:0] audio_haptic_peak_drive,
   output logic [7:0] motor_nominal_level,
   output logic [7:0] overdrive_limit,
   output logic [7:0] calib_loss_factor,
   output logic [7:0] calib_backemf_level,
   // derived references
   output logic [7:0] fullscale_ref,
   output logic [7:0] drive_level,
   output logic [8:0] loss_coef_num,
   output logic [18:0] bemf_fb_num,
   output logic [11:0] bemf_fb_den
);

   // ==========================================================
   // reset image
   localparam hdc_bank_type BANK_RST = '{
      state: ST_IDLE,
      bits: 4'h0,
      shift: 8'h00,
      ptr: 8'h00,
      ack: 1'b0,
      sda_oe: 1'b0,
      sda_lvl: 1'b0,
      peak: `HDC_RST_PEAK_DRIVE,
      nominal: `HDC_RST_NOMINAL,
      od: `HDC_RST_OD_LIMIT,
      loss: `HDC_RST_CAL_LOSS,
      bemf: `HDC_RST_CAL_BEMF
   };

   hdc_bank_type q;
   hdc_bank_type d;

   logic scl_lvl;
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl_s;
   logic sda_rise;
   logic sda_fall;
   logic start_seen;
   logic stop_seen;
   logic wr_en;
   logic [7:0] rd_cur;

   // ==========================================================
   // line sampling
   hdc_pin_track #(
      .IDLE_LEVEL(1'b1)
   ) u_scl (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pin_in(scl_in),
      .level(scl_lvl),
      .rise(scl_rise),
      .fall(scl_fall)
   );

   hdc_pin_track #(
      .IDLE_LEVEL(1'b1)
   ) u_sda (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .pin_in(sda_in),
      .level(sda_lvl_s),
      .rise(sda_rise),
      .fall(sda_fall)
   );

   // sda moves while scl is high only at start and stop
   assign start_seen = scl_lvl & sda_fall;
   assign stop_seen = scl_lvl & sda_rise;

   // ==========================================================
   // read multiplexer
   function automatic logic [7:0] rd_sel(
      input hdc_bank_type s,
      input logic [7:0] a
   );
      logic [7:0] v;
      v = `HDC_RD_UNMAPPED;
      case (a)
         `HDC_OFS_PEAK_DRIVE: v = s.peak;
         `HDC_OFS_NOMINAL: v = s.nominal;
         `HDC_OFS_OD_LIMIT: v = s.od;
         `HDC_OFS_CAL_LOSS: v = s.loss;
         `HDC_OFS_CAL_BEMF: v = s.bemf;
         default: v = `HDC_RD_UNMAPPED;
      endcase
      return v;
   endfunction

   assign rd_cur = rd_sel(q, q.ptr);

   // ==========================================================
   // slave sequencing and register update
   always_comb
   begin
      d = q;
      wr_en = 1'b0;
      d.sda_lvl = 1'b0;
      if (start_seen)
      begin
         d.state = ST_ADDR;
         d.bits = 4'h0;
         d.sda_oe = 1'b0;
      end
      else if (stop_seen)
      begin
         d.state = ST_IDLE;
         d.sda_oe = 1'b0;
      end
      else if (scl_rise)
      begin
         case (q.state)
            ST_ADDR, ST_PTR, ST_WDATA:
            begin
               d.shift = {q.shift[6:0], sda_lvl_s};
               d.bits = q.bits + 4'h1;
            end
            ST_RDATA:
            begin
               d.bits = q.bits + 4'h1;
            end
            ST_RDATA_ACK:
            begin
               // low means the host wants another byte
               d.ack = ~sda_lvl_s;
               if (~sda_lvl_s)
               begin
                  d.ptr = q.ptr + 8'h01;
               end
            end
            default:
            begin
               d.bits = q.bits;
            end
         endcase
      end
      else if (scl_fall)
      begin
         case (q.state)
            ST_ADDR:
            begin
               if (q.bits == `HDC_BITS_PER_BYTE)
               begin
                  if (q.shift[`HDC_ADDR_MSB:`HDC_ADDR_LSB] == DEV_ADDR)
                  begin
                     d.state = ST_ADDR_ACK;
                     d.sda_oe = 1'b1;
                  end
                  else
                  begin
                     d.state = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK:
            begin
               d.bits = 4'h0;
               if (q.shift[`HDC_RW_BIT])
               begin
                  d.state = ST_RDATA;
                  d.shift = rd_cur;
                  d.sda_oe = ~rd_cur[7];
               end
               else
               begin
                  d.state = ST_PTR;
                  d.sda_oe = 1'b0;
               end
            end
            ST_PTR:
            begin
               if (q.bits == `HDC_BITS_PER_BYTE)
               begin
                  d.ptr = q.shift;
                  d.state = ST_PTR_ACK;
                  d.sda_oe = 1'b1;
               end
            end
            ST_PTR_ACK:
            begin
               d.state = ST_WDATA;
               d.bits = 4'h0;
               d.sda_oe = 1'b0;
            end
            ST_WDATA:
            begin
               if (q.bits == `HDC_BITS_PER_BYTE)
               begin
                  wr_en = 1'b1;
                  d.state = ST_WDATA_ACK;
                  d.sda_oe = 1'b1;
               end
            end
            ST_WDATA_ACK:
            begin
               d.state = ST_WDATA;
               d.bits = 4'h0;
               d.ptr = q.ptr + 8'h01;
               d.sda_oe = 1'b0;
            end
            ST_RDATA:
            begin
               if (q.bits == `HDC_BITS_PER_BYTE)
               begin
                  d.state = ST_RDATA_ACK;
                  d.sda_oe = 1'b0;
               end
               else
               begin
                  d.shift = {q.shift[6:0], 1'b0};
                  d.sda_oe = ~q.shift[6];
               end
            end
            ST_RDATA_ACK:
            begin
               if (q.ack)
               begin
                  // pointer already advanced on the acknowledge edge
                  d.state = ST_RDATA;
                  d.bits = 4'h0;
                  d.shift = rd_cur;
                  d.sda_oe = ~rd_cur[7];
               end
               else
               begin
                  d.state = ST_IDLE;
                  d.sda_oe = 1'b0;
               end
            end
            default:
            begin
               d.sda_oe = 1'b0;
            end
         endcase
      end

      // host write into the addressed register
      if (wr_en)
      begin
         case (q.ptr)
            `HDC_OFS_PEAK_DRIVE: d.peak = q.shift; // [RULE1]
            `HDC_OFS_NOMINAL: d.nominal = q.shift; // [RULE2]
            `HDC_OFS_OD_LIMIT: d.od = q.shift; // [RULE6]
            `HDC_OFS_CAL_LOSS: d.loss = q.shift; // [RULE12]
            `HDC_OFS_CAL_BEMF: d.bemf = q.shift; // [RULE12]
            default: d.peak = d.peak;
         endcase
      end

      // calibration result wins over a host write in the same cycle
      if (cal_done)
      begin
         d.loss = cal_loss_result; // [RULE8]
         d.bemf = cal_backemf_result; // [RULE10]
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q <= BANK_RST;
      end
      else
      begin
         q <= d;
      end
   end

   // ==========================================================
   // derived references for the drive engine
   hdc_drive_calc #(
      .BEMF_SCALE_0(BEMF_SCALE_0),
      .BEMF_SCALE_1(BEMF_SCALE_1),
      .BEMF_SCALE_2(BEMF_SCALE_2),
      .BEMF_SCALE_3(BEMF_SCALE_3)
   ) u_calc (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .peak(q.peak),
      .nominal(q.nominal),
      .od(q.od),
      .loss(q.loss),
      .bemf(q.bemf),
      .open_loop(open_loop),
      .engine_level(engine_level),
      .backemf_scale_select(backemf_scale_select),
      .fullscale_ref(fullscale_ref),
      .drive_level(drive_level),
      .loss_coef_num(loss_coef_num),
      .bemf_fb_num(bemf_fb_num),
      .bemf_fb_den(bemf_fb_den)
   );

   // ==========================================================
   // outputs
   assign sda_out = q.sda_lvl;
   assign sda_oe = q.sda_oe;
   assign audio_haptic_peak_drive = q.peak;
   // nominal level also feeds calibration as its rated input
   assign motor_nominal_level = q.nominal; // [RULE4]
   assign overdrive_limit = q.od; // [RULE6]
   assign calib_loss_factor = q.loss;
   assign calib_backemf_level = q.bemf;

endmodule

//--- hdc_regs_chk.sv
/*
   port assertions for the calibration register bank.
   assumes it is bound to hdc_regs and runs on clk_sys.
*/
`timescale 1ns/1ps
module hdc_regs_chk
#(
   parameter logic [3:0] BEMF_SCALE_0 = 4'h1,
   parameter logic [3:0] BEMF_SCALE_1 = 4'h2,
   parameter logic [3:0] BEMF_SCALE_2 = 4'h3,
   parameter logic [3:0] BEMF_SCALE_3 = 4'h4
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // inputs
   input wire logic scl_in,
   input wire logic cal_done,
   input wire logic [7:0] cal_loss_result,
   input wire logic [7:0] cal_backemf_result,
   input wire logic open_loop,
   input wire logic [7:0] engine_level,
   input wire logic [1:0] backemf_scale_select,
   // outputs
   input wire logic sda_oe,
   input wire logic [7:0] audio_haptic_peak_drive,
   input wire logic [7:0] motor_nominal_level,
   input wire logic [7:0] overdrive_limit,
   input wire logic [7:0] calib_loss_factor,
   input wire logic [7:0] calib_backemf_level,
   input wire logic [7:0] fullscale_ref,
   input wire logic [7:0] drive_level,
   input wire logic [8:0] loss_coef_num,
   input wire logic [18:0] bemf_fb_num,
   input wire logic [11:0] bemf_fb_den
);
   logic [7:0] cap_v;
   logic [3:0] sc;
   logic [23:0] regs_v;
   assign cap_v = engine_level < audio_haptic_peak_drive ? engine_level :
      audio_haptic_peak_drive;
   assign sc = backemf_scale_select == 2'h0 ? BEMF_SCALE_0 :
      backemf_scale_select == 2'h1 ? BEMF_SCALE_1 :
      backemf_scale_select == 2'h2 ? BEMF_SCALE_2 : BEMF_SCALE_3;
   assign regs_v = {audio_haptic_peak_drive, motor_nominal_level,
      overdrive_limit};

   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   // ==========================================================
   // sequences
   sequence bus_quiet;
      scl_in [*8];
   endsequence
   sequence cal_pulse;
      cal_done ##1 1'b1;
   endsequence

   // ==========================================================
   // assertions
   chk_fs_closed: assert property (
      !open_loop |=> fullscale_ref == $past(motor_nominal_level))
      else $error("closed loop full scale wrong");
   chk_fs_open: assert property (
      open_loop |=> fullscale_ref == $past(overdrive_limit))
      else $error("open loop full scale wrong");
   chk_drive_cap: assert property (
      1'b1 |=> drive_level == $past(cap_v))
      else $error("drive level not capped");
   chk_loss_coef: assert property (
      1'b1 |=> loss_coef_num == 9'h0FF + 9'($past(calib_loss_factor)))
      else $error("loss coefficient wrong");
   chk_bemf_num: assert property (
      1'b1 |=> bemf_fb_num == 19'($past(calib_backemf_level)) * 19'h004C4)
      else $error("back-emf numerator wrong");
   chk_bemf_den: assert property (
      1'b1 |=> bemf_fb_den == 12'($past(sc)) * 12'h0FF)
      else $error("back-emf denominator wrong");
   chk_cal_load: assert property (
      cal_pulse |-> calib_loss_factor == $past(cal_loss_result)
      && calib_backemf_level == $past(cal_backemf_result))
      else $error("calibration results not stored");
   chk_regs_hold: assert property (
      bus_quiet |=> $stable(regs_v))
      else $error("register changed without bus write");
   chk_oe_scl_low: assert property (
      $changed(sda_oe) |-> !scl_in)
      else $error("data line changed while clock high");
endmodule

bind hdc_regs hdc_regs_chk #(
   .BEMF_SCALE_0(BEMF_SCALE_0), .BEMF_SCALE_1(BEMF_SCALE_1),
   .BEMF_SCALE_2(BEMF_SCALE_2), .BEMF_SCALE_3(BEMF_SCALE_3)
) u_chk (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_in),
   .cal_done(cal_done), .cal_loss_result(cal_loss_result),
   .cal_backemf_result(cal_backemf_result), .open_loop(open_loop),
   .engine_level(engine_level), .sda_oe(sda_oe),
   .backemf_scale_select(backemf_scale_select),
   .audio_haptic_peak_drive(audio_haptic_peak_drive),
   .motor_nominal_level(motor_nominal_level),
   .overdrive_limit(overdrive_limit), .calib_loss_factor(calib_loss_factor),
   .calib_backemf_level(calib_backemf_level),
   .fullscale_ref(fullscale_ref), .drive_level(drive_level),
   .loss_coef_num(loss_coef_num), .bemf_fb_num(bemf_fb_num),
   .bemf_fb_den(bemf_fb_den)
);

//--- hdc_host.sv
/*
   host model driving the serial control bus of the register bank.
   assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/1ps
module hdc_host
(
   // clock
   input wire logic clk_sys,
   // bus lines
   input wire logic sda_line,
   output logic scl_o,
   output logic sda_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // start or repeated start; clock low on exit
   task automatic bus_start();
      // wait for the slave to let go of an acknowledge before raising data
      wt(2);
      sda_o = 1'b1;
      wt(2);
      scl_o = 1'b1;
      wt(4);
      sda_o = 1'b0;
      wt(4);
      scl_o = 1'b0;
   endtask

   // one bit, clock low four cycles and high four
   task automatic bitx(input logic b, output logic r);
      wt(2);
      sda_o = b;
      wt(2);
      scl_o = 1'b1;
      wt(2);
      r = sda_line;
      wt(2);
      scl_o = 1'b0;
   endtask

   // byte out msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, input logic ak,
      output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r[i]);
      bitx(ak, a);
   endtask

   task automatic bus_stop();
      wt(2);
      sda_o = 1'b0;
      wt(2);
      scl_o = 1'b1;
      wt(4);
      sda_o = 1'b1;
      wt(4);
   endtask
endmodule

//--- tb_top.sv
/*
   self-checking bench for the calibration register bank.
   assumes hdc_host as bus partner and default back-emf scales 1..4.
*/
`timescale 1ns/1ps
module tb_top;
   import hdc_pkg::*;
   localparam logic [6:0] ADDR = 7'h2A;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic cal_done = 1'b0;
   logic open_loop = 1'b0;
   logic [7:0] cal_loss_result = 8'h00;
   logic [7:0] cal_backemf_result = 8'h00;
   logic [7:0] engine_level = 8'h00;
   logic [1:0] backemf_scale_select = 2'h0;
   logic [7:0] peak, nom, od, loss, bemf, fs, drv;
   logic [8:0] coef;
   logic [18:0] bnum;
   logic [11:0] bden;
   logic scl_o, sda_o, sda_oe, sda_out;
   wire sda_line = sda_o & ~(sda_oe & ~sda_out);
   logic [7:0] mdl [8'h15:8'h19] = '{8'hFF, 8'h3E, 8'h8C, 8'h0C, 8'h6F};
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   int seed_v;

   always #25 clk_sys = ~clk_sys;

   hdc_host host (.clk_sys(clk_sys), .sda_line(sda_line), .scl_o(scl_o),
      .sda_o(sda_o));

   hdc_regs #(.DEV_ADDR(ADDR)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .scl_in(scl_o), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .cal_done(cal_done), .cal_loss_result(cal_loss_result),
      .cal_backemf_result(cal_backemf_result), .open_loop(open_loop),
      .engine_level(engine_level), .backemf_scale_select(backemf_scale_select),
      .audio_haptic_peak_drive(peak), .motor_nominal_level(nom),
      .overdrive_limit(od), .calib_loss_factor(loss),
      .calib_backemf_level(bemf), .fullscale_ref(fs), .drive_level(drv),
      .loss_coef_num(coef), .bemf_fb_num(bnum), .bemf_fb_den(bden));

   // ==========================================================
   // checking and closing
   task automatic cmp(input string n, input logic [18:0] e,
      input logic [18:0] g);
      checked++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic end_of_test();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_total++;
         end_of_test();
      end
   end

   function automatic logic [7:0] exp_drive(input logic [7:0] l,
      input logic [7:0] p);
      return l < p ? l : p;
   endfunction

   function automatic logic [11:0] exp_den(input logic [1:0] s);
      return 12'h0FF * (12'(s) + 12'h001);
   endfunction

   function automatic logic [7:0] port_of(input int a);
      case (a)
         8'h15: return peak;
         8'h16: return nom;
         8'h17: return od;
         8'h18: return loss;
         default: return bemf;
      endcase
   endfunction

   // ==========================================================
   // bus cycles
   task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
      logic [7:0] r;
      logic a;
      host.bus_start();
      host.xfer({ADDR, 1'b0}, 1'b1, r, a);
      cmp("addr ack", 19'h0, 19'(a));
      host.xfer(p, 1'b1, r, a);
      cmp("ptr ack", 19'h0, 19'(a));
      for (int k = n - 1; k >= 0; k--)
      begin
         host.xfer(d[8*k+:8], 1'b1, r, a);
         cmp("data ack", 19'h0, 19'(a));
         if (p >= 8'h15 && p <= 8'h19)
            mdl[p] = d[8*k+:8];
         p++;
      end
      host.bus_stop();
   endtask

   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic [7:0] r;
      logic a;
      host.bus_start();
      host.xfer({ADDR, 1'b0}, 1'b1, r, a);
      host.xfer(p, 1'b1, r, a);
      host.bus_start();
      host.xfer({ADDR, 1'b1}, 1'b1, r, a);
      cmp("read ack", 19'h0, 19'(a));
      host.xfer(8'hFF, 1'b1, d, a);
      host.bus_stop();
   endtask

   task automatic chk_regs();
      logic [7:0] d;
      for (int q = 8'h15; q <= 8'h19; q++)
      begin
         rd(8'(q), d);
         cmp("bus read", 19'(mdl[q]), 19'(d));
         cmp("port", 19'(mdl[q]), 19'(port_of(q)));
      end
   endtask

   task automatic cal(input logic [7:0] l, input logic [7:0] b);
      cal_loss_result = l;
      cal_backemf_result = b;
      cal_done = 1'b1;
      host.wt(1);
      cal_done = 1'b0;
      mdl[8'h18] = l;
      mdl[8'h19] = b;
      host.wt(2);
   endtask

   task automatic chk_derived();
      for (int i = 0; i < 8; i++)
      begin
         open_loop = i[0];
         backemf_scale_select = 2'(i >> 1);
         engine_level = (i == 0) ? 8'hFF : 8'($urandom);
         host.wt(2);
         cmp("fullscale", 19'(i[0] ? mdl[8'h17] : mdl[8'h16]), 19'(fs));
         cmp("drive", 19'(exp_drive(engine_level, mdl[8'h15])), 19'(drv));
         cmp("coef", 19'(mdl[8'h18]) + 19'h000FF, 19'(coef));
         cmp("bemf num", 19'(mdl[8'h19]) * 19'h004C4, bnum);
         cmp("bemf den", 19'(exp_den(backemf_scale_select)), 19'(bden));
      end
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      logic [7:0] d;
      logic [7:0] r;
      logic a;
      seed_v = $urandom(59238);
      host.wt(3);
      sys_rst = 1'b0;
      host.wt(2);
      chk_regs();
      chk_derived();
      wr(8'h1A, 16'h00A5, 1);
      rd(8'h1A, d);
      cmp("unmapped", 19'h0, 19'(d));
      host.bus_start();
      host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, r, a);
      cmp("foreign nack", 19'h1, 19'(a));
      host.bus_stop();
      wr(8'h18, 16'($urandom), 2);
      wr(8'h15, 16'h0080, 1);
      for (int i = 0; i < 6; i++)
         wr(8'h16 + 8'($urandom_range(3)), 16'($urandom), 1);
      chk_regs();
      wr(8'h16, 16'($urandom), 1);
      cal(8'($urandom), 8'($urandom));
      chk_regs();
      wr(8'h16, 16'($urandom), 1);
      cal(8'($urandom), 8'($urandom));
      wr(8'h19, 16'($urandom), 1);
      chk_regs();
      chk_derived();
      end_of_test();
   end
endmodule
